// [inc/fds_pkg.sv]
// Constants and types for the fixed-point divide sequencer.
// Assumes a single 100 MHz clock and an AXI4-Lite master outside.
//
// Behaviour
// - Nonrestoring division of a true-form dividend; no in-loop fixes.
// - Init loads true halves and divisor, saves signs, clears counters; here Init loads only the halves, signs are saved at the start write.
// - Odd first operand field raises a specification exception.
// - Dividend is an even/odd pair; remainder to even, quotient to odd.
// - Exactly thirty-two reduction cycles precede termination.
// - Step counter counts pairs from zero; it picks byte and bit-pair.
// - Selected bit-pair is appended unchanged below the high half.
// - Multiple chosen by prior carry, divisor sign and active order.
// - Multiples are plus one, minus one, plus two, minus two divisor.
// - First reduction: plus two if divisor negative, else minus two.
// - Divisor sign fills upper adder bits; the sum is the new remainder.
// - Quotient bit is inverse of partial remainder sign.
// - Quotient orders alternate; each sets bit slot and multiple shift.
// - Even-step order: bit to odd slot of pair, multiple unshifted.
// - Odd-step order: bit to even slot of pair, multiple shifted left.
// - Quotient bytes overwrite used dividend bytes per byte counter.
// - Termination routine picked by divisor sign and quotient form; here digit word bit 31 alone picks it.
// - Quotient plus on like signs; remainder as dividend; zero is plus.
// - Unrepresentable quotient raises divide exception; operands kept.
// - An end-operation cycle follows the write-back of results.
// - Dividend and divisor sign flags captured at start and kept.
// - Negative halves negated apart; no low carry adds minus one high.
`default_nettype none

package fds_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] FDS_CTRL_OFS    = 8'h00;
  localparam logic [7:0] FDS_DVD_HI_OFS  = 8'h04;
  localparam logic [7:0] FDS_DVD_LO_OFS  = 8'h08;
  localparam logic [7:0] FDS_DIVISOR_OFS = 8'h0c;
  localparam logic [7:0] FDS_STATUS_OFS  = 8'h10;
  localparam logic [7:0] FDS_STEP_OFS    = 8'h14;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int FDS_CTRL_START_BIT = 0;
  localparam int FDS_CTRL_FIELD_LSB = 4;
  localparam int FDS_ST_BUSY_BIT    = 0;
  localparam int FDS_ST_DONE_BIT    = 1;
  localparam int FDS_ST_SPEC_BIT    = 2;
  localparam int FDS_ST_DIVX_BIT    = 3;

  // ---------------------------------------------------------------------
  // Counts and reset values
  // ---------------------------------------------------------------------
  localparam logic [4:0]  FDS_LAST_REDUCTION = 5'h1f;
  localparam logic [31:0] FDS_ZERO_WORD      = 32'h0000_0000;
  localparam logic [35:0] FDS_ACC_ZERO       = 36'h0_0000_0000;
  localparam logic [1:0]  FDS_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  FDS_RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    FDS_IDLE,
    FDS_INIT,
    FDS_LOOP,
    FDS_TERM,
    FDS_STORE,
    FDS_ENDOP
  } fds_state_t;

endpackage : fds_pkg

`default_nettype wire

// [hdl/fds_divide_sequencer.sv]
// Fixed-point nonrestoring divide sequencer with an AXI4-Lite slave.
// Assumes a 32-bit AXI4-Lite master on REF_CLK_I, synchronous reset.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none

module fds_divide_sequencer
  import fds_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output var  logic        AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output var  logic        WREADY_O,
  output var  logic [1:0]  BRESP_O,
  output var  logic        BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output var  logic        ARREADY_O,
  output var  logic [31:0] RDATA_O,
  output var  logic [1:0]  RRESP_O,
  output var  logic        RVALID_O,
  input  wire logic        RREADY_I,
  output var  logic        BUSY_O,
  output var  logic        END_OP_O,
  output var  logic        SPEC_EXC_O,
  output var  logic        DIV_EXC_O
);

  // ---------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        wr_fire;
  logic        wr_mapped;

  assign wr_fire   = aw_held_reg && w_held_reg && !BVALID_O;
  assign wr_mapped = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= FDS_STEP_OFS);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      AWREADY_O   <= 1'b0;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= AWADDR_I;
      AWREADY_O   <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else begin
      AWREADY_O <= !aw_held_reg && !BVALID_O;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      w_held_reg <= 1'b0;
      w_data_reg <= FDS_ZERO_WORD;
      w_strb_reg <= 4'h0;
      WREADY_O   <= 1'b0;
    end else if (WVALID_I && WREADY_O) begin
      w_held_reg <= 1'b1;
      w_data_reg <= WDATA_I;
      w_strb_reg <= WSTRB_I;
      WREADY_O   <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else begin
      WREADY_O <= !w_held_reg && !BVALID_O;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= FDS_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= wr_mapped ? FDS_RESP_OKAY : FDS_RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // Byte-lane merge helper: only lanes with their strobe bit set take the new data.
  function automatic logic [31:0] fds_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : fds_merge

  // ---------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------
  fds_state_t  state_reg;
  logic [31:0] dvd_hi_reg;
  logic [31:0] dvd_lo_reg;
  logic [31:0] divisor_reg;
  logic [3:0]  field_reg;
  logic        done_reg;
  logic        spec_reg;
  logic        divx_reg;
  logic        dvd_neg_reg;
  logic        div_neg_reg;
  logic [31:0] qd_reg;
  logic [35:0] acc_reg;
  logic        carry_reg;
  logic [4:0]  red_cnt_reg;
  logic [3:0]  step_cnt_reg;
  logic [1:0]  byte_cnt_reg;
  logic [7:0]  byte_latch_reg;
  logic [31:0] rem_res_reg;
  logic [31:0] quo_res_reg;
  logic        ovf_reg;

  logic start_req;
  logic idle;
  logic st_w1c;
  assign idle      = (state_reg == FDS_IDLE);
  assign st_w1c    = wr_fire && (aw_addr_reg == FDS_STATUS_OFS) && w_strb_reg[0];
  assign start_req = wr_fire && idle && (aw_addr_reg == FDS_CTRL_OFS)
                     && w_strb_reg[0] && w_data_reg[FDS_CTRL_START_BIT];

  // Operand registers act as the even/odd register pair; results land here.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dvd_hi_reg  <= FDS_ZERO_WORD;
      dvd_lo_reg  <= FDS_ZERO_WORD;
      divisor_reg <= FDS_ZERO_WORD;
      field_reg   <= 4'h0;
    end else if (state_reg == FDS_STORE && !ovf_reg) begin
      dvd_hi_reg <= rem_res_reg;
      dvd_lo_reg <= quo_res_reg;
    end else if (wr_fire && idle) begin
      case (aw_addr_reg)
        FDS_DVD_HI_OFS:  dvd_hi_reg  <= fds_merge(dvd_hi_reg, w_data_reg, w_strb_reg);
        FDS_DVD_LO_OFS:  dvd_lo_reg  <= fds_merge(dvd_lo_reg, w_data_reg, w_strb_reg);
        FDS_DIVISOR_OFS: divisor_reg <= fds_merge(divisor_reg, w_data_reg, w_strb_reg);
        FDS_CTRL_OFS: begin
          if (w_strb_reg[0]) begin
            field_reg <= w_data_reg[FDS_CTRL_FIELD_LSB +: 4];
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Datapath combinational terms
  // ---------------------------------------------------------------------
  logic        odd_order;
  logic [1:0]  sel_pair;
  logic        plus_mult;
  logic [35:0] div_ext;
  logic [35:0] mult;
  logic [35:0] base;
  logic [35:0] sum;
  logic        qbit;
  logic [31:0] lo_cmp;
  logic [31:0] hi_cmp;
  logic        lo_carry;
  logic [31:0] hi_true;
  logic [31:0] lo_true;

  // First of each pair runs the odd-step order, so orders alternate.
  assign odd_order = !red_cnt_reg[0];
  assign sel_pair  = qd_reg[5'd30 - {step_cnt_reg, 1'b0} +: 2];
  assign plus_mult = (red_cnt_reg != 5'h00 && carry_reg) ^ div_neg_reg;
  assign div_ext   = {{4{divisor_reg[31]}}, divisor_reg};
  always_comb begin
    mult = plus_mult ? div_ext : (36'h0 - div_ext);
    if (odd_order) begin
      mult = {mult[34:0], 1'b0};
      base = {acc_reg[33:0], sel_pair};
    end else begin
      base = acc_reg;
    end
  end
  assign sum  = base + mult;
  assign qbit = !sum[35];

  // Each half is complemented alone; missing low carry needs minus one high.
  assign {lo_carry, lo_cmp} = {1'b0, ~dvd_lo_reg} + 33'h1;
  assign hi_cmp  = ~dvd_hi_reg + 32'h1;
  assign hi_true = dvd_neg_reg ? (lo_carry ? hi_cmp : hi_cmp - 32'h1)
                               : dvd_hi_reg;
  assign lo_true = dvd_neg_reg ? lo_cmp : dvd_lo_reg;

  // ---------------------------------------------------------------------
  // Control sequence
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg <= FDS_IDLE;
    end else begin
      case (state_reg)
        FDS_IDLE:  if (start_req && !w_data_reg[FDS_CTRL_FIELD_LSB]) begin
                     state_reg <= FDS_INIT;
                   end
        FDS_INIT:  state_reg <= FDS_LOOP;
        FDS_LOOP:  if (red_cnt_reg == FDS_LAST_REDUCTION) begin
                     state_reg <= FDS_TERM;
                   end
        FDS_TERM:  state_reg <= FDS_STORE;
        FDS_STORE: state_reg <= FDS_ENDOP;
        FDS_ENDOP: state_reg <= FDS_IDLE;
        default:   state_reg <= FDS_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dvd_neg_reg <= 1'b0;
      div_neg_reg <= 1'b0;
    end else if (start_req) begin
      dvd_neg_reg <= dvd_hi_reg[31];
      div_neg_reg <= divisor_reg[31];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      qd_reg         <= FDS_ZERO_WORD;
      acc_reg        <= FDS_ACC_ZERO;
      carry_reg      <= 1'b0;
      red_cnt_reg    <= 5'h00;
      step_cnt_reg   <= 4'h0;
      byte_cnt_reg   <= 2'h0;
      byte_latch_reg <= 8'h00;
    end else if (state_reg == FDS_INIT) begin
      qd_reg         <= lo_true;
      acc_reg        <= {4'h0, hi_true};
      carry_reg      <= 1'b0;
      red_cnt_reg    <= 5'h00;
      step_cnt_reg   <= 4'h0;
      byte_cnt_reg   <= 2'h0;
      byte_latch_reg <= 8'h00;
    end else if (state_reg == FDS_LOOP) begin
      acc_reg     <= sum;
      carry_reg   <= sum[35];
      red_cnt_reg <= red_cnt_reg + 5'h01;
      if (odd_order) begin
        byte_latch_reg[3'd7 - {step_cnt_reg[1:0], 1'b0}] <= qbit;
      end else begin
        byte_latch_reg[3'd6 - {step_cnt_reg[1:0], 1'b0}] <= qbit;
        step_cnt_reg <= step_cnt_reg + 4'h1;
        if (step_cnt_reg[1:0] == 2'h3) begin
          qd_reg[5'd24 - {byte_cnt_reg, 3'h0} +: 8] <=
            {byte_latch_reg[7:1], qbit};
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Termination: digit word to magnitude, then one of two sign routines
  // ---------------------------------------------------------------------
  logic [33:0] q_mag;
  logic [35:0] r_fix;
  logic [32:0] div_mag;
  logic        hi_too_big;
  assign div_mag    = div_neg_reg ? (33'h0 - {1'b1, divisor_reg})
                                  : {1'b0, divisor_reg};
  // A true high half not below the divisor magnitude means a quotient of
  // two to the 32nd or more; the loop remainder would also outgrow the
  // accumulator, so its digits cannot be trusted then.
  assign hi_too_big = {1'b0, hi_true} >= div_mag;
  always_comb begin
    // Each digit is the inverted sign of its own step's result, so the digit word
    // already is the quotient magnitude once the remainder is set right.
    q_mag = {2'b00, qd_reg};
    r_fix = acc_reg;
    // A final negative remainder is set right only after the loop.
    if (acc_reg[35]) begin
      r_fix = acc_reg + {3'h0, div_mag};
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rem_res_reg <= FDS_ZERO_WORD;
      quo_res_reg <= FDS_ZERO_WORD;
      ovf_reg     <= 1'b0;
    end else if (state_reg == FDS_TERM) begin
      rem_res_reg <= dvd_neg_reg ? (32'h0 - r_fix[31:0]) : r_fix[31:0];
      // An initial high half not below the divisor means quotient overflow.
      case ({div_neg_reg, q_mag[31]})
        2'b00, 2'b10: begin
          quo_res_reg <= (dvd_neg_reg ^ div_neg_reg) ? (32'h0 - q_mag[31:0])
                                                     : q_mag[31:0];
          ovf_reg <= q_mag[33:32] != 2'h0;
        end
        2'b01, 2'b11: begin
          quo_res_reg <= 32'h0 - q_mag[31:0];
          ovf_reg <= !(dvd_neg_reg ^ div_neg_reg) || q_mag[33:32] != 2'h0
                     || q_mag[30:0] != 31'h0;
        end
        default: ovf_reg <= 1'b1;
      endcase
      if (hi_too_big) begin
        ovf_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Status flags and event outputs (set beats clear)
  // ---------------------------------------------------------------------
  logic spec_set;
  logic divx_set;
  logic done_set;
  assign spec_set = start_req && w_data_reg[FDS_CTRL_FIELD_LSB];
  assign divx_set = (state_reg == FDS_STORE) && ovf_reg;
  assign done_set = (state_reg == FDS_ENDOP);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      done_reg <= 1'b0;
      spec_reg <= 1'b0;
      divx_reg <= 1'b0;
    end else begin
      done_reg <= done_set || (done_reg && !(st_w1c && w_data_reg[FDS_ST_DONE_BIT]));
      spec_reg <= spec_set || (spec_reg && !(st_w1c && w_data_reg[FDS_ST_SPEC_BIT]));
      divx_reg <= divx_set || (divx_reg && !(st_w1c && w_data_reg[FDS_ST_DIVX_BIT]));
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      BUSY_O     <= 1'b0;
      END_OP_O   <= 1'b0;
      SPEC_EXC_O <= 1'b0;
      DIV_EXC_O  <= 1'b0;
    end else begin
      BUSY_O     <= !idle || start_req;
      END_OP_O   <= done_set;
      SPEC_EXC_O <= spec_set;
      DIV_EXC_O  <= divx_set;
    end
  end

  // ---------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = FDS_ZERO_WORD;
    case (ARADDR_I)
      FDS_CTRL_OFS:    rd_word[FDS_CTRL_FIELD_LSB +: 4] = field_reg;
      FDS_DVD_HI_OFS:  rd_word = dvd_hi_reg;
      FDS_DVD_LO_OFS:  rd_word = dvd_lo_reg;
      FDS_DIVISOR_OFS: rd_word = divisor_reg;
      FDS_STATUS_OFS:  rd_word[3:0] = {divx_reg, spec_reg, done_reg, !idle};
      FDS_STEP_OFS:    rd_word[12:0] = {red_cnt_reg, byte_cnt_reg, 2'h0,
                                        step_cnt_reg};
      default:         rd_word = FDS_ZERO_WORD;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= FDS_ZERO_WORD;
      RRESP_O   <= FDS_RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RDATA_O   <= rd_word;
      RRESP_O   <= (ARADDR_I[1:0] == 2'h0 && ARADDR_I <= FDS_STEP_OFS)
                   ? FDS_RESP_OKAY : FDS_RESP_SLVERR;
    end else if (RVALID_O) begin
      if (RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end else begin
      ARREADY_O <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  property p_spec;
    spec_set |=> spec_reg && state_reg == FDS_IDLE ##1 SPEC_EXC_O == 1'b0;
  endproperty
  a_spec: assert property (p_spec) else $error("odd field not refused");

  property p_init;
    state_reg == FDS_INIT |=> step_cnt_reg == 4'h0 && byte_cnt_reg == 2'h0
      && red_cnt_reg == 5'h00;
  endproperty
  a_init: assert property (p_init) else $error("counters not cleared");

  property p_len;
    $rose(state_reg == FDS_LOOP) |-> ##31 state_reg == FDS_LOOP ##1
      state_reg == FDS_TERM;
  endproperty
  a_len: assert property (p_len) else $error("loop not 32 cycles");

  property p_alt;
    state_reg == FDS_LOOP && $past(state_reg) == FDS_LOOP |->
      odd_order != $past(odd_order);
  endproperty
  a_alt: assert property (p_alt) else $error("orders not alternating");

  property p_step;
    state_reg == FDS_LOOP && !odd_order |=>
      step_cnt_reg == $past(step_cnt_reg) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("step count wrong");

  property p_first;
    state_reg == FDS_LOOP && red_cnt_reg == 5'h00 |-> plus_mult == div_neg_reg;
  endproperty
  a_first: assert property (p_first) else $error("first multiple wrong");

  property p_keep;
    divx_set |=> dvd_hi_reg == $past(dvd_hi_reg) && dvd_lo_reg == $past(dvd_lo_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("overflow changed operands");

  property p_endop;
    state_reg == FDS_STORE |=> state_reg == FDS_ENDOP ##1 END_OP_O && idle;
  endproperty
  a_endop: assert property (p_endop) else $error("end-op cycle missing");

  c_spec: cover property (spec_set);
  c_done: cover property (done_set && !ovf_reg);
  c_ovf:  cover property (divx_set);

endmodule : fds_divide_sequencer

`default_nettype wire

// [verification/fds_host_model.sv]
// Host model: the control side that reaches the sequencer over AXI4-Lite.
// Assumes the caller enters a task just after a rising clock edge.
`default_nettype none

module fds_host_model (
  input  wire logic        clk_i,
  output var  logic [7:0]  awaddr_o,
  output var  logic        awvalid_o,
  input  wire logic        awready_i,
  output var  logic [31:0] wdata_o,
  output var  logic [3:0]  wstrb_o,
  output var  logic        wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output var  logic        bready_o,
  output var  logic [7:0]  araddr_o,
  output var  logic        arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output var  logic        rready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hf;
  end

  // Each channel drops its valid only at the edge that took it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    r = 2'h3;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!got && n < 500) begin
      @(posedge clk_i);
      n++;
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'b0;
        got = 1;
      end
    end
    if (!got) hung = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    r = 2'h3;
    d = '0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!got && n < 500) begin
      @(posedge clk_i);
      n++;
      if (arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        got = 1;
      end
    end
    if (!got) hung = 1'b1;
  endtask : rd
endmodule : fds_host_model

`default_nettype wire

// [verification/fixed_point_divide_sequencer_tb.sv]
// Self-checking bench for the divide sequencer.
// Assumes the host model drives every bus input of the sequencer.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module fixed_point_divide_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fds_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy, end_op, spec, divx;
  int n_mismatch = 0, checks_done = 0, n_end = 0, n_spec = 0, n_divx = 0;

  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (end_op === 1'b1) n_end++;
    if (spec === 1'b1) n_spec++;
    if (divx === 1'b1) n_divx++;
  end

  fds_divide_sequencer DUT (.REF_CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .BUSY_O(busy),
    .END_OP_O(end_op), .SPEC_EXC_O(spec), .DIV_EXC_O(divx));
  fds_host_model M (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    M.wr(a, d, r);
    if (M.hung) begin
      n_mismatch++;
      end_sim();
    end
    `CHK(r, FDS_RESP_OKAY)
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    M.rd(a, d, r);
    if (M.hung) begin
      n_mismatch++;
      end_sim();
    end
  endtask : rd

  // Expected results come from 64-bit integer division of the operands.
  task automatic divide(input logic [31:0] hi, lo, dv, input logic [3:0] fld);
    longint dd, ds, q, rm;
    int n, e0, s0, x0;
    logic [31:0] d;
    logic [1:0] r;
    bit ovf;
    dd = $signed({hi, lo});
    ds = $signed(dv);
    ovf = (ds == 0);
    if (!ovf) begin
      q = dd / ds;
      rm = dd % ds;
      ovf = (q > 64'sd2147483647) || (q < -64'sd2147483648);
    end
    wr(FDS_DVD_HI_OFS, hi);
    wr(FDS_DVD_LO_OFS, lo);
    wr(FDS_DIVISOR_OFS, dv);
    {e0, s0, x0} = {n_end, n_spec, n_divx};
    wr(FDS_CTRL_OFS, {24'h0, fld, 4'h1});
    @(negedge clk);
    `CHK(busy, !fld[0])
    n = 0;
    while ({n_end, n_spec, n_divx} == {e0, s0, x0} && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      end_sim();
    end
    rd(FDS_STATUS_OFS, d, r);
    `CHK(d[FDS_ST_BUSY_BIT], 1'b0)
    if (fld[0]) begin
      `CHK(n_spec - s0, 1)
      `CHK(d[FDS_ST_SPEC_BIT], 1'b1)
    end else if (ovf) begin
      `CHK(n_divx - x0, 1)
      `CHK(d[FDS_ST_DIVX_BIT], 1'b1)
    end else begin
      `CHK(n_end - e0, 1)
      `CHK(d[FDS_ST_DONE_BIT], 1'b1)
      `CHK((n >= 33 && n <= 40), 1'b1)
    end
    rd(FDS_DVD_HI_OFS, d, r);
    `CHK(d, (fld[0] || ovf) ? hi : rm[31:0])
    rd(FDS_DVD_LO_OFS, d, r);
    `CHK(d, (fld[0] || ovf) ? lo : q[31:0])
    wr(FDS_STATUS_OFS, 32'h0000_000e);
    rd(FDS_STATUS_OFS, d, r);
    `CHK(d[3:0], 4'h0)
  endtask : divide

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(FDS_STATUS_OFS, d, r);
    `CHK(d[3:0], 4'h0)
    rd(8'h40, d, r);
    `CHK({r, d}, {FDS_RESP_SLVERR, FDS_ZERO_WORD})
    divide(32'h0, 32'd100, 32'd7, 4'h2);
    divide(32'hffff_ffff, -32'sd100, 32'd7, 4'h0);
    divide(32'h0, 32'd100, -32'sd7, 4'h4);
    divide(32'hffff_ffff, -32'sd100, -32'sd7, 4'he);
    divide(32'hffff_ffff, -32'sd70, 32'd7, 4'h6);
    divide(32'h0, 32'h0, 32'd5, 4'h8);
    divide(32'h1234_5678, 32'h9abc_def0, 32'h7fff_ffff, 4'ha);
    divide(32'hffff_ffff, 32'h8000_0000, 32'd1, 4'hc);
    divide(32'h0000_0001, 32'h0, 32'd2, 4'h2);
    divide(32'h0, 32'd5, 32'h0, 4'h2);
    divide(32'h0, 32'd100, 32'd7, 4'h3);
    divide(32'hffff_fff0, 32'h0, -32'sd3, 4'h0);
    end_sim();
  end
endmodule : fixed_point_divide_sequencer_tb

`default_nettype wire
